/* rtl/mmbc_pkg.sv */
// constants and types for the memory map and mode bus controller
package mmbc_pkg;
    // oscillator rate and bus clock division
    localparam int unsigned OSC_HZ = 25_000_000;
    localparam int unsigned BUS_DIV = 4;
    localparam int unsigned SLOW_FACTOR = 2;
    localparam logic [2:0] LAST_NORMAL = 3'(BUS_DIV - 1);
    localparam logic [2:0] LAST_SLOW = 3'(BUS_DIV * SLOW_FACTOR - 1);
    // internal map
    localparam logic [15:0] RAM_LO = 16'h0000;
    localparam logic [15:0] RAM_HI = 16'h007F;
    localparam int unsigned RAM_WORDS = 128;
    localparam logic [15:0] SFR_LO = 16'h00D0;
    localparam logic [15:0] SFR_HI = 16'h00FF;
    localparam logic [15:0] ROM_LO = 16'hF000;
    localparam logic [15:0] ROM_HI = 16'hFFFF;
    localparam logic [15:0] VEC_LO = 16'hFFE0;
    localparam int unsigned ROM_WORDS = 4096;
    // register offsets
    localparam logic [7:0] PORT0_DATA_OFS = 8'hD0;
    localparam logic [7:0] PORT0_DIRECTION_OFS = 8'hD1;
    localparam logic [7:0] PORT1_DATA_OFS = 8'hD2;
    localparam logic [7:0] PORT1_DIRECTION_OFS = 8'hD3;
    localparam logic [7:0] PORT2_DATA_OFS = 8'hD4;
    localparam logic [7:0] PORT2_DIRECTION_OFS = 8'hD5;
    localparam logic [7:0] MISC_MODE_CONTROL_OFS = 8'hDF;
    localparam int unsigned NUM_PORTS = 3;
    // misc_mode_control fields
    localparam int unsigned MODE_SELECT_LOW_BIT = 0;
    localparam int unsigned MODE_SELECT_HIGH_BIT = 1;
    localparam int unsigned SLOW_BUS_WAIT_BIT = 6;
    localparam logic [7:0] MISC_KEEP_MASK = 8'hBC;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET = 8'h00;
    localparam logic [7:0] PORT_DRIVE_NONE = 8'hFF;

    typedef enum logic [1:0] {
        MMBC_SINGLE_CHIP,
        MMBC_MEM_EXPAND,
        MMBC_MICROPROC,
        MMBC_INHIBIT
    } mmbc_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
    } mmbc_req_t;

    typedef struct packed {
        logic [7:0] in;
        logic [7:0] out;
        logic [7:0] oe_n;
    } mmbc_pin_t;
endpackage : mmbc_pkg

/* rtl/mmbc_top.sv */
// memory map decode, processor mode and external bus control
module mmbc_top import mmbc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core access port
    input wire logic cpu_req,
    input wire mmbc_req_t cpu_cmd,
    output logic cpu_busy,
    output logic cpu_ack,
    output logic [7:0] cpu_rdata,
    // program memory load
    input wire logic rom_wr,
    input wire logic [11:0] rom_waddr,
    input wire logic [7:0] rom_wdata,
    // mode and clock control
    input wire logic boot_level_pin,
    input wire logic halt_req,
    output logic [1:0] mode_out,
    output logic bus_clk_out,
    output logic rw_out,
    // port pins
    input wire logic [7:0] low_address_port_in,
    output logic [7:0] low_address_port_out,
    output logic [7:0] low_address_port_oe_n,
    input wire logic [7:0] high_address_port_in,
    output logic [7:0] high_address_port_out,
    output logic [7:0] high_address_port_oe_n,
    input wire logic [7:0] data_bus_port_in,
    output logic [7:0] data_bus_port_out,
    output logic [7:0] data_bus_port_oe_n
);
    typedef enum logic {ST_IDLE, ST_ACTIVE} mmbc_state_t;

    logic [7:0] ram_r [RAM_WORDS];
    logic [7:0] rom_r [ROM_WORDS];
    logic [7:0] port_data_r [NUM_PORTS];
    logic [7:0] port_dir_r [NUM_PORTS];
    logic [7:0] port_pin_in [NUM_PORTS];
    logic [7:0] misc_r;
    logic [7:0] misc_nxt;
    logic boot_r;
    mmbc_state_t state_r;
    mmbc_req_t pend_r;
    mmbc_req_t cur_r;
    logic pend_v_r;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] last_r;
    logic [2:0] last_nxt;
    logic wrap;
    logic done;
    logic expand;
    logic hit_ram;
    logic hit_sfr;
    logic hit_rom;
    logic [7:0] sfr_rd_core;
    logic [7:0] int_rd;
    logic core_sfr_wr;
    logic [7:0] sfr_waddr;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    mmbc_pin_t pin_nxt [NUM_PORTS];

    assign port_pin_in[0] = low_address_port_in;
    assign port_pin_in[1] = high_address_port_in;
    assign port_pin_in[2] = data_bus_port_in;

    assign expand = (misc_r[1:0] == MMBC_MEM_EXPAND)
        || (misc_r[1:0] == MMBC_MICROPROC);

    // address decode of the access in progress
    assign hit_ram = (cur_r.addr <= RAM_HI);
    assign hit_sfr = (cur_r.addr >= SFR_LO) && (cur_r.addr <= SFR_HI);
    assign hit_rom = (cur_r.addr >= ROM_LO)
        && (misc_r[1:0] != MMBC_MICROPROC);

    // sfr read view, port registers hidden in expansion
    function automatic logic [7:0] sfr_read(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            PORT0_DATA_OFS: v = expand ? 8'h00 : port_data_r[0];
            PORT0_DIRECTION_OFS: v = expand ? 8'h00 : port_dir_r[0];
            PORT1_DATA_OFS: v = expand ? 8'h00 : port_data_r[1];
            PORT1_DIRECTION_OFS: v = expand ? 8'h00 : port_dir_r[1];
            PORT2_DATA_OFS: v = expand ? 8'h00 : port_data_r[2];
            PORT2_DIRECTION_OFS: v = expand ? 8'h00 : port_dir_r[2];
            MISC_MODE_CONTROL_OFS: v = misc_r;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : sfr_read

    // a process, so state read inside the function also wakes it
    always_comb begin
        sfr_rd_core = sfr_read(cur_r.addr[7:0]);
    end

    // internal data wins over the bus on overlapping reads
    always_comb begin
        if (hit_ram) begin
            int_rd = ram_r[cur_r.addr[6:0]];
        end else if (hit_sfr) begin
            int_rd = sfr_rd_core;
        end else if (hit_rom) begin
            int_rd = rom_r[cur_r.addr[11:0]];
        end else if (expand) begin
            int_rd = data_bus_port_in;
        end else begin
            int_rd = 8'h00;
        end
    end

    // bus cycle divider
    // halt freezes the count, so no cycle starts or ends
    assign wrap = (cnt_r == last_r) && !halt_req;
    assign done = wrap && (state_r == ST_ACTIVE);
    assign core_sfr_wr = done && cur_r.we && hit_sfr;

    // register port has priority over the core on a shared write
    always_comb begin
        if (reg_wr) begin
            sfr_wr = 1'b1;
            sfr_waddr = reg_addr;
            sfr_wdata = reg_wdata;
        end else begin
            sfr_wr = core_sfr_wr;
            sfr_waddr = cur_r.addr[7:0];
            sfr_wdata = cur_r.wdata;
        end
    end

    // next mode register value
    always_comb begin
        misc_nxt = misc_r;
        if (sfr_wr && sfr_waddr == MISC_MODE_CONTROL_OFS) begin
            misc_nxt = (misc_r & ~MISC_KEEP_MASK)
                | (sfr_wdata & MISC_KEEP_MASK);
            misc_nxt[SLOW_BUS_WAIT_BIT] = sfr_wdata[SLOW_BUS_WAIT_BIT];
            if (boot_r) begin
                misc_nxt[1:0] = MMBC_MICROPROC;
            end else if (sfr_wdata[1:0] != MMBC_INHIBIT) begin
                misc_nxt[1:0] = sfr_wdata[1:0];
            end else begin
                misc_nxt[1:0] = misc_r[1:0];
            end
        end
    end

    // new length is chosen at the wrap, after any flag write
    assign last_nxt = misc_nxt[SLOW_BUS_WAIT_BIT]
        ? LAST_SLOW : LAST_NORMAL;
    assign cnt_nxt = halt_req ? cnt_r : (wrap ? 3'h0 : cnt_r + 3'h1);

    // boot level capture
    always_ff @(posedge clk) begin
        if (!rstn) begin
            boot_r <= boot_level_pin;
        end
    end

    // mode register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            misc_r <= MISC_RESET;
            if (boot_level_pin) begin
                misc_r[1:0] <= MMBC_MICROPROC;
            end else begin
                misc_r[1:0] <= MMBC_SINGLE_CHIP;
            end
        end else begin
            misc_r <= misc_nxt;
        end
    end

    // port data and direction registers
    generate
        for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    port_data_r[i] <= PORT_RESET;
                    port_dir_r[i] <= PORT_RESET;
                end else if (sfr_wr && !expand) begin
                    if (sfr_waddr == PORT0_DATA_OFS + 8'(2 * i)) begin
                        port_data_r[i] <= sfr_wdata;
                    end
                    if (sfr_waddr == PORT0_DIRECTION_OFS + 8'(2 * i)) begin
                        port_dir_r[i] <= sfr_wdata;
                    end
                end
            end
            always_comb begin
                pin_nxt[i].in = port_pin_in[i];
                pin_nxt[i].out = port_data_r[i];
                pin_nxt[i].oe_n = ~port_dir_r[i];
            end
        end
    endgenerate

    // internal ram, written also when the bus writes overlap
    always_ff @(posedge clk) begin
        if (done && cur_r.we && hit_ram) begin
            ram_r[cur_r.addr[6:0]] <= cur_r.wdata;
        end
    end

    // program memory image load
    always_ff @(posedge clk) begin
        if (rom_wr) begin
            rom_r[rom_waddr] <= rom_wdata;
        end
    end

    // divider counter and cycle length
    always_ff @(posedge clk) begin
        if (!rstn) begin
            // start on the wrap count so the first low phase is full
            cnt_r <= LAST_NORMAL;
            last_r <= LAST_NORMAL;
        end else begin
            cnt_r <= cnt_nxt;
            if (wrap) begin
                last_r <= last_nxt;
            end
        end
    end

    // bus clock: low first half, high second half, high when halted
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_clk_out <= 1'b1;
        end else if (halt_req) begin
            bus_clk_out <= 1'b1;
        end else if (wrap) begin
            bus_clk_out <= 1'b0;
        end else begin
            bus_clk_out <= (cnt_nxt > (last_r >> 1));
        end
    end

    // request capture
    // a new request wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_v_r <= 1'b0;
            pend_r <= '0;
        end else if (cpu_req && !cpu_busy) begin
            pend_v_r <= 1'b1;
            pend_r <= cpu_cmd;
        end else if (wrap && state_r == ST_IDLE) begin
            pend_v_r <= 1'b0;
        end else if (done) begin
            pend_v_r <= 1'b0;
        end
    end

    // bus cycle sequencer, cycles start only at a divider wrap
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            cur_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (wrap && pend_v_r) begin
                        state_r <= ST_ACTIVE;
                        cur_r <= pend_r;
                    end
                end
                ST_ACTIVE: begin
                    if (done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // core answer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cpu_busy <= 1'b0;
            cpu_ack <= 1'b0;
            cpu_rdata <= 8'h00;
        end else begin
            cpu_ack <= done;
            if (cpu_req && !cpu_busy) begin
                cpu_busy <= 1'b1;
            end else if (done) begin
                cpu_busy <= 1'b0;
            end
            if (done && !cur_r.we) begin
                cpu_rdata <= int_rd;
            end
        end
    end

    // register port read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= sfr_read(reg_addr);
        end
    end

    // pins: ports in single-chip, address and data bus in expansion
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_out <= MMBC_SINGLE_CHIP;
            rw_out <= 1'b1;
            low_address_port_out <= 8'h00;
            low_address_port_oe_n <= PORT_DRIVE_NONE;
            high_address_port_out <= 8'h00;
            high_address_port_oe_n <= PORT_DRIVE_NONE;
            data_bus_port_out <= 8'h00;
            data_bus_port_oe_n <= PORT_DRIVE_NONE;
        end else begin
            mode_out <= misc_r[1:0];
            // pins trail the sequencer state by one clock
            if (expand) begin
                rw_out <= !(state_r == ST_ACTIVE && cur_r.we);
                low_address_port_out <= cur_r.addr[7:0];
                low_address_port_oe_n <= 8'h00;
                high_address_port_out <= cur_r.addr[15:8];
                high_address_port_oe_n <= 8'h00;
                data_bus_port_out <= cur_r.wdata;
                data_bus_port_oe_n <= (state_r == ST_ACTIVE && cur_r.we)
                    ? 8'h00 : PORT_DRIVE_NONE;
            end else begin
                rw_out <= !(state_r == ST_ACTIVE && cur_r.we);
                low_address_port_out <= pin_nxt[0].out;
                low_address_port_oe_n <= pin_nxt[0].oe_n;
                high_address_port_out <= pin_nxt[1].out;
                high_address_port_oe_n <= pin_nxt[1].oe_n;
                data_bus_port_out <= pin_nxt[2].out;
                data_bus_port_oe_n <= pin_nxt[2].oe_n;
            end
        end
    end
endmodule : mmbc_top

/* test/mmbc_ext_mem.sv */
// external memory model on the address and data ports
module mmbc_ext_mem (
    // clock
    input wire logic clk,
    // pins from the controller
    input wire logic [7:0] addr_lo,
    input wire logic [7:0] addr_hi,
    input wire logic rw,
    input wire logic [7:0] dout,
    input wire logic [7:0] oe_n,
    output logic [7:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // store bytes of write cycles
    always @(posedge clk) begin
        if (!rw && oe_n == 8'h00) begin
            mem[{addr_hi, addr_lo}] <= dout;
        end
        last_r <= din;
    end
    // answer reads only, otherwise a changing pattern
    assign din = rw ? mem[{addr_hi, addr_lo}] : ~last_r;
endmodule : mmbc_ext_mem

/* test/mmbc_top_properties.sv */
// port assertions for the bus controller
module mmbc_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // core port
    input wire logic cpu_req,
    input wire logic cpu_busy,
    input wire logic cpu_ack,
    // mode and bus
    input wire logic halt_req,
    input wire logic [1:0] mode_out,
    input wire logic bus_clk_out,
    input wire logic rw_out,
    input wire logic [7:0] low_address_port_oe_n,
    input wire logic [7:0] data_bus_port_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_take;
        cpu_req && !cpu_busy;
    endsequence
    sequence s_done;
        cpu_ack && !cpu_busy;
    endsequence
    property p_busy; s_take |=> cpu_busy; endproperty
    property p_done; s_take |-> ##[5:18] s_done; endproperty
    property p_pulse; cpu_ack |=> !cpu_ack; endproperty
    property p_mode; mode_out != 2'b11; endproperty
    property p_rw; !rw_out |-> (cpu_busy || cpu_ack); endproperty
    property p_dir;
        mode_out != 2'b00 |-> (!rw_out == (data_bus_port_oe_n == 8'h00));
    endproperty
    property p_addr;
        mode_out != 2'b00 && $stable(mode_out)
            |-> low_address_port_oe_n == 8'h00;
    endproperty
    property p_low;
        $fell(bus_clk_out) && !halt_req && !$past(halt_req, 2)
            |=> !bus_clk_out;
    endproperty
    property p_lowmax; !bus_clk_out [*4] |=> bus_clk_out; endproperty
    property p_halt; halt_req [*2] |-> bus_clk_out; endproperty
    a_busy: assert property (p_busy)
        else $error("busy not raised after request");
    a_done: assert property (p_done)
        else $error("bus cycle did not complete in time");
    a_pulse: assert property (p_pulse)
        else $error("ack longer than one cycle");
    a_mode: assert property (p_mode)
        else $error("prohibited mode shown");
    a_rw: assert property (p_rw)
        else $error("write level outside a bus cycle");
    a_dir: assert property (p_dir)
        else $error("data port direction differs from rw");
    a_addr: assert property (p_addr)
        else $error("address port not driven in expansion");
    a_low: assert property (p_low)
        else $error("bus clock low phase too short");
    a_lowmax: assert property (p_lowmax)
        else $error("bus clock low phase too long");
    a_halt: assert property (p_halt)
        else $error("bus clock not high while halted");
endmodule : mmbc_top_props

bind mmbc_top mmbc_top_props mmbc_top_props_i (
    .clk(clk),
    .rstn(rstn),
    .cpu_req(cpu_req),
    .cpu_busy(cpu_busy),
    .cpu_ack(cpu_ack),
    .halt_req(halt_req),
    .mode_out(mode_out),
    .bus_clk_out(bus_clk_out),
    .rw_out(rw_out),
    .low_address_port_oe_n(low_address_port_oe_n),
    .data_bus_port_oe_n(data_bus_port_oe_n)
);

/* test/mmbc_top_tb.sv */
// self-checking bench for the bus controller
module mmbc_top_tb;
    import mmbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] a; logic we; logic [7:0] d;} mmbc_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cpu_req = 1'b0;
    mmbc_req_t cpu_cmd = '0;
    logic rom_wr = 1'b0;
    logic [11:0] rom_waddr = 12'h000;
    logic [7:0] rom_wdata = 8'h00;
    logic boot = 1'b0;
    logic halt_req = 1'b0;
    logic [7:0] reg_rdata, cpu_rdata, lo_out, lo_oe_n, hi_out, hi_oe_n;
    logic [7:0] d_in, d_out, d_oe_n;
    logic cpu_busy, cpu_ack, bus_clk_out, rw_out;
    logic [1:0] mode_out;
    int mismatches = 0;
    int n_tests = 0;
    int len;
    mmbc_row_t rows [11] = '{
        '{16'h0010, 1'b1, 8'h11}, '{16'h0010, 1'b0, 8'h11},
        '{16'h007F, 1'b1, 8'hC3}, '{16'h007F, 1'b0, 8'hC3},
        '{16'h8001, 1'b1, 8'h99}, '{16'h8001, 1'b0, 8'h99},
        '{16'h8000, 1'b0, 8'h77}, '{16'h0080, 1'b0, 8'h42},
        '{16'hF000, 1'b0, 8'hA5}, '{16'hFFE0, 1'b0, 8'h5A},
        '{16'h00DF, 1'b0, 8'h01}};

    always #20 clk = ~clk;

    mmbc_top mmbc_top_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd),
        .cpu_busy(cpu_busy), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
        .rom_wr(rom_wr), .rom_waddr(rom_waddr), .rom_wdata(rom_wdata),
        .boot_level_pin(boot), .halt_req(halt_req), .mode_out(mode_out),
        .bus_clk_out(bus_clk_out), .rw_out(rw_out),
        .low_address_port_in(8'h00), .low_address_port_out(lo_out),
        .low_address_port_oe_n(lo_oe_n), .high_address_port_in(8'h00),
        .high_address_port_out(hi_out), .high_address_port_oe_n(hi_oe_n),
        .data_bus_port_in(d_in), .data_bus_port_out(d_out),
        .data_bus_port_oe_n(d_oe_n));
    mmbc_ext_mem mmbc_ext_mem_i (.clk(clk), .addr_lo(lo_out),
        .addr_hi(hi_out), .rw(rw_out), .dout(d_out), .oe_n(d_oe_n),
        .din(d_in));

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rreg(input logic wr, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
    endtask : rreg

    task automatic acc(input logic [15:0] a, input logic we,
                       input logic [7:0] d);
        int k;
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_cmd <= {a, d, we};
        @(posedge clk);
        cpu_req <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (cpu_ack !== 1'b1 && k < 40);
        if (k >= 40) chk("ack", 8'h01, 8'h00);
    endtask : acc

    task automatic rom_w(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        rom_wr <= 1'b1;
        rom_waddr <= a;
        rom_wdata <= d;
        @(posedge clk);
        rom_wr <= 1'b0;
    endtask : rom_w

    task automatic low_len();
        repeat (10) if (bus_clk_out !== 1'b1) @(negedge clk);
        len = 0;
        repeat (20) begin
            @(negedge clk);
            if (bus_clk_out === 1'b0) len++;
            else if (len > 0) break;
        end
    endtask : low_len

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #400us;
        mismatches++;
        test_done();
    end

    initial begin
        mmbc_ext_mem_i.mem[16'h8000] = 8'h77;
        mmbc_ext_mem_i.mem[16'h0080] = 8'h42;
        mmbc_ext_mem_i.mem[16'hF000] = 8'h3C;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rreg(1'b0, MISC_MODE_CONTROL_OFS, 8'h00);
        chk("misc reset", MISC_RESET, reg_rdata);
        chk("mode", 8'h00, {6'h00, mode_out});
        rreg(1'b1, PORT0_DATA_OFS, 8'h3C);
        rreg(1'b1, PORT0_DIRECTION_OFS, 8'h0F);
        rreg(1'b0, PORT0_DATA_OFS, 8'h00);
        chk("port0 sc", 8'h3C, reg_rdata);
        chk("port0 pins", 8'h3C, lo_out);
        chk("port0 oe_n", 8'hF0, lo_oe_n);
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h40);
        low_len();
        chk("slow low", 8'h04, 8'(len));
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h00);
        low_len();
        chk("normal low", 8'h02, 8'(len));
        rom_w(12'h000, 8'hA5);
        rom_w(12'hFE0, 8'h5A);
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h01);
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].we, rows[i].d);
            if (!rows[i].we) chk("rd", rows[i].d, cpu_rdata);
        end
        chk("mode", 8'h01, {6'h00, mode_out});
        chk("addr lo", 8'hDF, lo_out);
        chk("addr hi", 8'h00, hi_out);
        chk("addr hi oe_n", 8'h00, hi_oe_n);
        chk("data oe_n", 8'hFF, d_oe_n);
        chk("rw idle", 8'h01, {7'h00, rw_out});
        chk("ext copy", 8'h11, mmbc_ext_mem_i.mem[16'h0010]);
        mmbc_ext_mem_i.mem[16'h0010] = 8'hEE;
        acc(16'h0010, 1'b0, 8'h00);
        chk("overlap rd", 8'h11, cpu_rdata);
        rreg(1'b1, PORT0_DATA_OFS, 8'hAA);
        rreg(1'b0, PORT0_DATA_OFS, 8'h00);
        chk("port0", 8'h00, reg_rdata);
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h02);
        acc(16'hF000, 1'b0, 8'h00);
        chk("ext rom", 8'h3C, cpu_rdata);
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h03);
        @(negedge clk);
        chk("keep mode", 8'h02, {6'h00, mode_out});
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h42);
        acc(16'h8000, 1'b0, 8'h00);
        chk("slow rd", 8'h77, cpu_rdata);
        rreg(1'b0, MISC_MODE_CONTROL_OFS, 8'h00);
        chk("wait flag", 8'h40, reg_rdata & 8'h40);
        rreg(1'b1, MISC_MODE_CONTROL_OFS, 8'h00);
        rreg(1'b0, PORT0_DATA_OFS, 8'h00);
        chk("port0 kept", 8'h3C, reg_rdata);
        @(posedge clk);
        halt_req <= 1'b1;
        repeat (10) @(negedge clk);
        chk("halt clk", 8'h01, {7'h00, bus_clk_out});
        @(posedge clk);
        halt_req <= 1'b0;
        boot <= 1'b1;
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rreg(1'b0, MISC_MODE_CONTROL_OFS, 8'h00);
        chk("boot bits", 8'h02, reg_rdata & 8'h43);
        @(posedge clk);
        boot <= 1'b0;
        repeat (4) @(negedge clk);
        chk("boot mode", 8'h02, {6'h00, mode_out});
        test_done();
    end
endmodule : mmbc_top_tb
